// ===== hw/drive_relay_pkg.sv
package drive_relay_pkg;

    // Speed selection codes, lowest rank first.
    typedef enum logic [2:0] {
        SPEED_NONE = 3'h0,
        SPEED_SLOW = 3'h1,
        SPEED_INSPECTION = 3'h2,
        SPEED_MIDDLE = 3'h3,
        SPEED_FAST = 3'h4
    } speed_t;

    // Programmable input function codes.
    typedef enum logic {
        PIN_FAULT_CLEAR = 1'b0,
        PIN_LIMIT_COUNT = 1'b1
    } pin_mode_t;

    // Drive sequencer states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DRIVE = 2'b01,
        ST_FAULT = 2'b11
    } drive_state_t;

    localparam int LIMIT_COUNT_WIDTH = 16;
    localparam logic [15:0] LIMIT_COUNT_RESET = 16'h0000;
    localparam drive_state_t STATE_RESET = ST_IDLE;

endpackage : drive_relay_pkg

// ===== hw/speed_priority_decoder.sv
`timescale 1ns/10ps

module speed_priority_decoder (
    // Speed select inputs.
    input wire logic slowSpeedSel,
    input wire logic inspectionSpeedSel,
    input wire logic middleSpeedSel,
    input wire logic fastSpeedSel,
    // Decoded speed.
    output drive_relay_pkg::speed_t speedSel
);

    always_comb begin
        if (fastSpeedSel) begin
            speedSel = drive_relay_pkg::SPEED_FAST;
        end else if (middleSpeedSel) begin
            speedSel = drive_relay_pkg::SPEED_MIDDLE;
        end else if (inspectionSpeedSel) begin
            speedSel = drive_relay_pkg::SPEED_INSPECTION;
        end else if (slowSpeedSel) begin
            speedSel = drive_relay_pkg::SPEED_SLOW;
        end else begin
            speedSel = drive_relay_pkg::SPEED_NONE;
        end
    end

endmodule : speed_priority_decoder

// ===== hw/drive_command_relay_sequencer.sv
`timescale 1ns/10ps

// Notes on behaviour
// - Among several asserted speed selects only the highest ranked one counts.
// - Programmable input acts as fault clear or limit counter, chosen by setting.
// - Driving starts only once the run permit shows contactors closed.
// - Driving stops as soon as the run permit is withdrawn.
// - Driving continues while the run permit stays asserted and no overcurrent occurs, whatever contactors do.
// - Overcurrent while driving raises the power module fault.
// - Fault relay is energized normally and released on power module fault (overcurrent while driving); overcurrent while idle leaves it energized.
// - Running relay is energized exactly while the motor is driven.
// - Brake relay energized to lift the brake, released to apply it.
module drive_command_relay_sequencer #(
    parameter int COUNT_WIDTH = drive_relay_pkg::LIMIT_COUNT_WIDTH
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    // Speed selects.
    input wire logic slowSpeedSel,
    input wire logic inspectionSpeedSel,
    input wire logic middleSpeedSel,
    input wire logic fastSpeedSel,
    // Direction and permit.
    input wire logic travelUpward,
    input wire logic travelDownward,
    input wire logic runPermit,
    // Programmable input and its function setting.
    input wire logic progInput,
    input wire logic progInputMode,
    // Power stage feedback.
    input wire logic overCurrent,
    // Motor command.
    output logic motorDrive,
    output logic motorDirDown,
    output drive_relay_pkg::speed_t motorSpeed,
    // Status.
    output logic powerModuleFault,
    output logic [COUNT_WIDTH-1:0] limitCount,
    // Relays.
    output logic faultRelay,
    output logic runningRelay,
    output logic brakeRelay
);

    drive_relay_pkg::speed_t decodedSpeed;
    drive_relay_pkg::drive_state_t state_q;
    drive_relay_pkg::drive_state_t state_d;
    logic progInput_q;
    logic progRise;
    logic faultClear;
    logic dirValid;
    logic [COUNT_WIDTH-1:0] count_q;

    speed_priority_decoder u_decoder (
        .slowSpeedSel(slowSpeedSel),
        .inspectionSpeedSel(inspectionSpeedSel),
        .middleSpeedSel(middleSpeedSel),
        .fastSpeedSel(fastSpeedSel),
        .speedSel(decodedSpeed)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // one direction only
    assign dirValid = travelUpward ^ travelDownward;

    assign progRise = progInput & ~progInput_q;
    assign faultClear = progRise & (progInputMode == drive_relay_pkg::PIN_FAULT_CLEAR);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            progInput_q <= 1'b0;
        end else begin
            progInput_q <= progInput;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= COUNT_WIDTH'(drive_relay_pkg::LIMIT_COUNT_RESET);
        end else if (progRise && progInputMode == drive_relay_pkg::PIN_LIMIT_COUNT) begin
            count_q <= count_q + COUNT_WIDTH'(1);
        end
    end
    assign limitCount = count_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer. A fault latches until cleared while the permit has dropped and no overcurrent is present.
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            drive_relay_pkg::ST_IDLE: begin
                if (runPermit && dirValid && decodedSpeed != drive_relay_pkg::SPEED_NONE) begin
                    state_d = drive_relay_pkg::ST_DRIVE;
                end
            end
            drive_relay_pkg::ST_DRIVE: begin
                if (overCurrent) begin
                    state_d = drive_relay_pkg::ST_FAULT;
                end else if (!runPermit) begin
                    state_d = drive_relay_pkg::ST_IDLE;
                end
            end
            drive_relay_pkg::ST_FAULT: begin
                if (faultClear && !runPermit && !overCurrent) begin
                    state_d = drive_relay_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = drive_relay_pkg::ST_FAULT;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= drive_relay_pkg::STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Direction is latched at start so relay bounce mid-run is harmless; speed follows the decoded select every cycle while driving.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            motorSpeed <= drive_relay_pkg::SPEED_NONE;
            motorDirDown <= 1'b0;
        end else if (state_d != drive_relay_pkg::ST_DRIVE) begin
            motorSpeed <= drive_relay_pkg::SPEED_NONE;
        end else begin
            motorSpeed <= decodedSpeed;
            if (state_q == drive_relay_pkg::ST_IDLE) begin
                motorDirDown <= travelDownward;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // running relay follows drive
    assign motorDrive = (state_q == drive_relay_pkg::ST_DRIVE);
    assign runningRelay = motorDrive;
    assign brakeRelay = motorDrive;
    assign powerModuleFault = (state_q == drive_relay_pkg::ST_FAULT);
    assign faultRelay = ~powerModuleFault;

    ////////////////////////////////////////////////////////////////////////////////
    sequence s_permitUp;
        runPermit && dirValid && decodedSpeed != drive_relay_pkg::SPEED_NONE;
    endsequence

    sequence s_idleStart;
        state_q == drive_relay_pkg::ST_IDLE && !overCurrent ##0 s_permitUp;
    endsequence

    sequence s_clearRequest;
        faultClear && !runPermit && !overCurrent;
    endsequence

    a_start_needs_permit: assert property (
        @(posedge clk) disable iff (!reset_n) $rose(motorDrive) |-> $past(runPermit))
        else $error("drive began without run permit");
    a_start_on_permit: assert property (
        @(posedge clk) disable iff (!reset_n) s_idleStart |=> motorDrive)
        else $error("drive did not start on permit");
    a_stop_on_drop: assert property (
        @(posedge clk) disable iff (!reset_n) motorDrive && !runPermit |=> !motorDrive)
        else $error("drive continued after permit dropped");
    a_hold_on_permit: assert property (
        @(posedge clk) disable iff (!reset_n)
        motorDrive && runPermit && !overCurrent |=> motorDrive)
        else $error("drive stopped while permitted");
    a_fault_on_oc: assert property (
        @(posedge clk) disable iff (!reset_n)
        motorDrive && overCurrent |=> powerModuleFault && !faultRelay && !motorDrive)
        else $error("overcurrent did not raise fault");
    a_fault_relay_idle: assert property (
        @(posedge clk) disable iff (!reset_n) !powerModuleFault |-> faultRelay)
        else $error("fault relay released without failure");
    a_running_relay: assert property (
        @(posedge clk) disable iff (!reset_n) runningRelay == (state_q == drive_relay_pkg::ST_DRIVE))
        else $error("running relay mismatch");
    a_brake_relay: assert property (
        @(posedge clk) disable iff (!reset_n) brakeRelay |-> motorDrive && !powerModuleFault)
        else $error("brake lifted without drive");
    a_speed_fast: assert property (
        @(posedge clk) disable iff (!reset_n)
        motorDrive && fastSpeedSel && $past(motorDrive) ##1 motorDrive
        |-> motorSpeed == drive_relay_pkg::SPEED_FAST)
        else $error("fast select not given priority");
    a_limit_count: assert property (
        @(posedge clk) disable iff (!reset_n)
        progRise && progInputMode == drive_relay_pkg::PIN_LIMIT_COUNT
        |=> limitCount == $past(limitCount) + COUNT_WIDTH'(1))
        else $error("limit counter did not step");
    a_direction_one: assert property (
        @(posedge clk) disable iff (!reset_n) $rose(motorDrive) |-> $past(dirValid))
        else $error("drive began without single direction");
    a_fault_clear: assert property (
        @(posedge clk) disable iff (!reset_n)
        powerModuleFault ##0 s_clearRequest |=> !powerModuleFault && !motorDrive)
        else $error("fault clear request ignored");
    a_fault_latched: assert property (
        @(posedge clk) disable iff (!reset_n)
        powerModuleFault && !faultClear |=> powerModuleFault)
        else $error("fault dropped without clear request");
    a_count_hold: assert property (
        @(posedge clk) disable iff (!reset_n)
        progInputMode == drive_relay_pkg::PIN_FAULT_CLEAR |=> $stable(limitCount))
        else $error("limit counter moved in fault clear mode");
    a_direction_latch: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(motorDrive) |-> motorDirDown == $past(travelDownward))
        else $error("motor direction not taken from select");

endmodule : drive_command_relay_sequencer

// ===== tb/lift_controller_model.sv
`timescale 1ns/10ps

module lift_controller_model (
    // Clock.
    input wire logic clk,
    // Commands from the bench.
    input wire logic reqRun,
    input wire logic [3:0] reqSpeed,
    input wire logic [1:0] reqDir,
    // Feedback from the drive.
    input wire logic runningRelay,
    // Lines to the drive.
    output logic [3:0] speedSel,
    output logic [1:0] dirSel,
    output logic runPermit
);
    logic closed_q;

    assign speedSel = reqSpeed | {3'h0, reqSpeed[3]};
    assign dirSel = reqDir;
    always_ff @(posedge clk) begin
        if (reqRun) begin
            closed_q <= 1'b1;
        end else if (!runningRelay) begin
            closed_q <= 1'b0;
        end
    end
    assign runPermit = reqRun & closed_q;
endmodule : lift_controller_model

// ===== tb/tb_top.sv
`timescale 1ns/10ps

module tb_top;
    logic clk, resetN, reqRun, progIn, progMode, overCur, runPermit;
    logic [3:0] reqSpeed, speedSel;
    logic [1:0] reqDir, dirSel;
    logic motorDrive, motorDirDown, powerModuleFault, faultRelay, runningRelay, brakeRelay;
    drive_relay_pkg::speed_t motorSpeed;
    logic [15:0] limitCount, refCount;
    logic [1:0] refState;
    logic [2:0] refSpeed;
    logic refDir, progPrev;
    logic [31:0] seed;
    logic [24:0] seen, expd;
    logic [24:0] notes[$];
    logic [9:0] plan[$];
    int errTotal, checked, cycles;

    lift_controller_model i_lift_controller_model (.clk(clk), .reqRun(reqRun),
        .reqSpeed(reqSpeed), .reqDir(reqDir), .runningRelay(runningRelay),
        .speedSel(speedSel), .dirSel(dirSel), .runPermit(runPermit));
    drive_command_relay_sequencer i_drive_command_relay_sequencer (.clk(clk),
        .reset_n(resetN), .slowSpeedSel(speedSel[0]), .inspectionSpeedSel(speedSel[1]),
        .middleSpeedSel(speedSel[2]), .fastSpeedSel(speedSel[3]),
        .travelUpward(dirSel[0]), .travelDownward(dirSel[1]), .runPermit(runPermit),
        .progInput(progIn), .progInputMode(progMode), .overCurrent(overCur),
        .motorDrive(motorDrive), .motorDirDown(motorDirDown), .motorSpeed(motorSpeed),
        .powerModuleFault(powerModuleFault), .limitCount(limitCount),
        .faultRelay(faultRelay), .runningRelay(runningRelay), .brakeRelay(brakeRelay));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic check(input string name, input logic [24:0] got, input logic [24:0] exp);
        checked++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic tally_and_finish;
        if (errTotal == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    // Bits: run, speeds fast..slow, down, up, programmable input, its mode, overcurrent.
    task automatic step(input logic [9:0] v);
        logic [2:0] pr;
        logic rise;
        @(negedge clk);
        {reqRun, reqSpeed, reqDir, progIn, progMode, overCur} = v;
        #1;
        pr = speedSel[3] ? 3'h4 : speedSel[2] ? 3'h3 : speedSel[1] ? 3'h2 : {2'h0, speedSel[0]};
        rise = progIn & !progPrev;
        if (progMode && rise) begin
            refCount++;
        end
        if (refState == 2'h2) begin
            if (!progMode && rise && !runPermit && !overCur) begin
                refState = 2'h0;
            end
        end else if (refState == 2'h1) begin
            refState = overCur ? 2'h2 : !runPermit ? 2'h0 : 2'h1;
        end else if (runPermit && ^dirSel && pr != 3'h0) begin
            refState = 2'h1;
            refDir = dirSel[1];
        end
        progPrev = progIn;
        refSpeed = refState == 2'h1 ? pr : 3'h0;
        notes.push_back({refState == 2'h1, refDir, refSpeed, refState == 2'h2,
            refState != 2'h2, refState == 2'h1, refState == 2'h1, refCount});
    endtask : step

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 1000) begin
            errTotal++;
            tally_and_finish();
        end
    end

    always @(posedge clk) begin
        #1;
        if (notes.size() > 0) begin
            expd = notes.pop_front();
            seen = {motorDrive, motorDirDown, motorSpeed, powerModuleFault, faultRelay,
                runningRelay, brakeRelay, limitCount};
            check("outputs", seen, expd);
        end
    end

    initial begin
        resetN = 1'b0;
        {reqRun, reqSpeed, reqDir, progIn, progMode, overCur} = 10'h000;
        {refState, refDir, refCount, progPrev} = '0;
        seed = 32'h3e34;
        notes.push_back(25'h0040000);
        repeat (2) @(posedge clk);
        @(negedge clk);
        resetN = 1'b1;
        plan = '{10'h308, 10'h308, 10'h308, 10'h2c8, 10'h248, 10'h0c8, 10'h000, 10'h228,
            10'h228, 10'h228, 10'h000, 10'h318, 10'h318, 10'h208, 10'h310, 10'h310,
            10'h310, 10'h311, 10'h314, 10'h010, 10'h000, 10'h004, 10'h006, 10'h002,
            10'h006, 10'h000};
        foreach (plan[i]) begin
            step(plan[i]);
        end
        repeat (300) begin
            seed = xorshift(seed);
            step({seed[22:21] != 2'h0, seed[8:5], (seed[15:13] == 3'h0) ? seed[4:3] :
                (seed[10] ? 2'h2 : 2'h1), seed[2:1], seed[20:17] == 4'h0});
        end
        repeat (2) @(posedge clk);
        tally_and_finish();
    end
endmodule : tb_top
